/* dv/rvc_chk.sv */
// Checker for the reset and vector control block
`timescale 1ns/1ps
`default_nettype none
module rvc_chk (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        power_on_det,
    input wire logic        reset_pin_n,
    input wire logic        wdt_enable,
    input wire logic        wdt_expire,
    input wire logic        irq_take,
    input wire logic        irq_ack,
    input wire logic        cpu_rst,
    input wire logic        io_rst,
    input wire logic        wdt_rst_pulse,
    input wire logic        power_on_flag,
    input wire logic        external_reset_flag,
    input wire logic        global_ie,
    input wire logic [15:0] vector_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence pin_low; !reset_pin_n [*2]; endsequence
    sequence wdt_hit; wdt_enable && $rose(wdt_expire); endsequence
    chk_vec_reset: assert property (cpu_rst |-> vector_addr == 16'h0000)
        else $error("vector not zero in reset");
    chk_pin_hold: assert property (pin_low |-> ##[0:2] cpu_rst)
        else $error("pin low gave no reset");
    chk_pin_flag: assert property (pin_low |-> ##[0:3] external_reset_flag)
        else $error("pin reset flag not set");
    chk_wdt_fire: assert property (wdt_hit |-> ##[0:2] wdt_rst_pulse)
        else $error("watchdog gave no pulse");
    chk_wdt_width: assert property (wdt_rst_pulse |=> !wdt_rst_pulse)
        else $error("watchdog pulse too long");
    chk_por_flag: assert property (power_on_det |=> power_on_flag && cpu_rst)
        else $error("power on not held");
    chk_take_gate: assert property ($rose(irq_take) |-> $past(global_ie) && !cpu_rst)
        else $error("interrupt taken while disabled");
    chk_ack_entry: assert property (irq_take && irq_ack |=> !global_ie && !irq_take)
        else $error("entry did not clear enable");
    chk_rel_sync: assert property ($fell(cpu_rst) |-> !io_rst && reset_pin_n)
        else $error("release while source active");
endmodule // rvc_chk
bind rvc_reset_vector rvc_chk chk_u (.clk(clk), .sys_rst(sys_rst), .power_on_det(power_on_det),
    .reset_pin_n(reset_pin_n), .wdt_enable(wdt_enable), .wdt_expire(wdt_expire),
    .irq_take(irq_take), .irq_ack(irq_ack), .cpu_rst(cpu_rst), .io_rst(io_rst),
    .wdt_rst_pulse(wdt_rst_pulse), .power_on_flag(power_on_flag),
    .external_reset_flag(external_reset_flag), .global_ie(global_ie), .vector_addr(vector_addr));
`default_nettype wire

/* dv/rvc_cpu_model.sv */
// CPU core model that accepts presented interrupts
`timescale 1ns/1ps
`default_nettype none
module rvc_cpu_model (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic        irq_take,
    input  wire logic [15:0] vector_addr,
    output var  logic        irq_ack = 1'b0,
    output var  logic [15:0] taken_vec = 16'hFFFF
);
    logic [3:0] wait_reg = 4'h0;
    always @(posedge clk) begin
        irq_ack <= 1'b0;
        if (irq_take && !irq_ack) begin
            wait_reg <= wait_reg + 4'h1;
            // Slow mode holds the request pending for several cycles
            if (wait_reg >= (slow ? 4'h6 : 4'h0)) begin
                irq_ack   <= 1'b1;
                taken_vec <= vector_addr;
                wait_reg  <= 4'h0;
            end
        end
    end
endmodule // rvc_cpu_model
`default_nettype wire

/* dv/tb_top.sv */
// Testbench for the reset and vector control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0, sys_rst = 1'b1, power_on_det = 1'b1, reset_pin_n = 1'b1;
    logic        wdt_enable = 1'b0, wdt_expire = 1'b0, wdt_osc_tick = 1'b0, slow = 1'b0;
    logic        flag_clear_power_on = 1'b0, flag_clear_external = 1'b0, global_ie_set = 1'b0;
    logic        global_ie_clear = 1'b0;
    logic [1:0]  startup_time_fuse = 2'h1;
    logic [22:0] irq_flag = 23'h0, irq_set = 23'h0, irq_enable = 23'h0;
    wire         irq_ack, cpu_rst, io_rst, wdt_rst_pulse, power_on_flag, external_reset_flag;
    wire         global_ie, irq_take;
    wire  [15:0] vector_addr, taken_vec;
    wire  [22:0] irq_flag_clear;
    int          error_cnt = 0, tests_run = 0;
    always #12.5 clk = ~clk;
    rvc_reset_vector #(.CYC_512(8), .CYC_4K(16), .CYC_16K(32)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .power_on_det(power_on_det), .reset_pin_n(reset_pin_n),
        .wdt_enable(wdt_enable), .wdt_expire(wdt_expire), .wdt_osc_tick(wdt_osc_tick),
        .startup_time_fuse(startup_time_fuse), .flag_clear_power_on(flag_clear_power_on),
        .flag_clear_external(flag_clear_external), .irq_flag(irq_flag), .irq_enable(irq_enable),
        .global_ie_set(global_ie_set), .global_ie_clear(global_ie_clear), .irq_ack(irq_ack),
        .cpu_rst(cpu_rst), .io_rst(io_rst), .wdt_rst_pulse(wdt_rst_pulse),
        .power_on_flag(power_on_flag), .external_reset_flag(external_reset_flag),
        .global_ie(global_ie), .irq_take(irq_take), .vector_addr(vector_addr),
        .irq_flag_clear(irq_flag_clear));
    rvc_cpu_model cpu_u (.clk(clk), .slow(slow), .irq_take(irq_take),
        .vector_addr(vector_addr), .irq_ack(irq_ack), .taken_vec(taken_vec));
    // Pending flags, cleared by the block on vectoring
    always @(posedge clk) irq_flag <= (irq_flag | irq_set) & ~irq_flag_clear;
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n); repeat (n) @(posedge clk); endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk) wdt_osc_tick <= 1'b1;
            @(posedge clk) wdt_osc_tick <= 1'b0;
        end
    endtask
    task automatic release_after(input int lim);
        cyc(4);
        ticks(lim - 1);
        cyc(2);
        check("hold", cpu_rst, 1'b1);
        ticks(1);
        cyc(3);
        check("run", cpu_rst, 1'b0);
    endtask
    task automatic t_power_on;
        check("por flag", power_on_flag, 1'b1);
        check("vec", vector_addr, 16'h0000);
        reset_pin_n <= 1'b0;
        @(posedge clk) power_on_det <= 1'b0;
        ticks(40);
        check("extended", cpu_rst, 1'b1);
        check("io rst", io_rst, 1'b1);
        reset_pin_n <= 1'b1;
        release_after(8);
        $display("test power_on done");
    endtask
    task automatic t_pin;
        for (int c = 0; c < 4; c++) begin
            startup_time_fuse <= c[1:0];
            flag_clear_external <= 1'b1;
            @(posedge clk) flag_clear_external <= 1'b0;
            reset_pin_n <= 1'b0;
            cyc(4);
            check("ext flag", external_reset_flag, 1'b1);
            check("pin rst", cpu_rst, 1'b1);
            reset_pin_n <= 1'b1;
            if (c == 0) begin
                cyc(6);
                check("fast hold", cpu_rst, 1'b1);
                cyc(2);
                check("fast", cpu_rst, 1'b0);
            end else release_after(4 << c);
        end
        $display("test pin done");
    endtask
    task automatic t_wdt;
        logic [3:0] n;
        n = 4'h0;
        startup_time_fuse <= 2'h1;
        wdt_expire <= 1'b1;
        @(posedge clk) wdt_expire <= 1'b0;
        cyc(4);
        check("wdt off", cpu_rst, 1'b0);
        {flag_clear_power_on, flag_clear_external, wdt_enable, wdt_expire} <= 4'hF;
        @(posedge clk) {flag_clear_power_on, flag_clear_external, wdt_expire} <= 3'h0;
        repeat (6) @(posedge clk) n += wdt_rst_pulse;
        check("pulse len", n, 4'h1);
        check("wdt rst", cpu_rst, 1'b1);
        check("por kept", power_on_flag, 1'b0);
        check("ext kept", external_reset_flag, 1'b0);
        wdt_enable <= 1'b0;
        release_after(8);
        $display("test wdt done");
    endtask
    task automatic t_irq;
        irq_set <= 23'h400001;
        @(posedge clk) irq_set <= 23'h0;
        cyc(4);
        check("masked", irq_take, 1'b0);
        irq_enable <= 23'h7FFFFF;
        {global_ie_set, global_ie_clear} <= 2'h3;
        @(posedge clk) {global_ie_set, global_ie_clear} <= 2'h0;
        cyc(3);
        check("no ie", irq_take, 1'b0);
        check("clear wins", global_ie, 1'b0);
        for (int i = 0; i < 23; i++) begin
            slow <= i[0];
            irq_set <= 23'h1 << i;
            global_ie_set <= 1'b1;
            @(posedge clk) {irq_set, global_ie_set} <= 24'h0;
            for (int k = 0; k < 40 && irq_ack !== 1'b1; k++) @(posedge clk);
            cyc(3);
            check("vector", taken_vec, 16'h0002 + 16'(2 * i));
            check("ie off", global_ie, 1'b0);
            check("flag off", irq_flag[i], 1'b0);
        end
        $display("test irq done");
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        cyc(5);
        sys_rst <= 1'b0;
        cyc(3);
        t_power_on;
        t_pin;
        t_wdt;
        t_irq;
        stop_test;
    end
    initial begin
        #(25 * 30000);
        error_cnt++;
        stop_test;
    end
endmodule // tb_top
`default_nettype wire

/* logic/rvc_prio_enc.v */
// Priority encoder from pending enabled sources to vector address
`timescale 1ns/1ps
`default_nettype none
`include "rvc_consts.vh"
module rvc_prio_enc #(
    parameter N = 23
) (
    input  wire [N-1:0] req,
    output reg          any,
    output reg  [4:0]   idx,
    output reg  [15:0]  vec
);
    integer i;
    always @* begin
        any = 1'b0;
        idx = 5'h00;
        // Downward scan so the lowest index is last written
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (req[i]) begin
                any = 1'b1;
                idx = i[4:0];
            end
        end
        vec = `RVC_VEC_RESET + `RVC_VEC_STEP * {11'h000, idx + 5'h01};
    end
endmodule // rvc_prio_enc
`default_nettype wire

/* logic/rvc_reset_vector.v */
// Reset sequencer and interrupt vector selection
`timescale 1ns/1ps
`default_nettype none
`include "rvc_consts.vh"
module rvc_reset_vector #(
    parameter N_IRQ       = `RVC_NUM_IRQ,
    parameter CYC_512     = `RVC_CYC_512,
    parameter CYC_4K      = `RVC_CYC_4K,
    parameter CYC_16K     = `RVC_CYC_16K
) (
    input  wire             clk,
    input  wire             sys_rst,
    input  wire             power_on_det,
    input  wire             reset_pin_n,
    input  wire             wdt_enable,
    input  wire             wdt_expire,
    input  wire             wdt_osc_tick,
    input  wire [1:0]       startup_time_fuse,
    input  wire             flag_clear_power_on,
    input  wire             flag_clear_external,
    input  wire [N_IRQ-1:0] irq_flag,
    input  wire [N_IRQ-1:0] irq_enable,
    input  wire             global_ie_set,
    input  wire             global_ie_clear,
    input  wire             irq_ack,
    output reg              cpu_rst,
    output reg              io_rst,
    output reg              wdt_rst_pulse,
    output reg              power_on_flag,
    output reg              external_reset_flag,
    output reg              global_ie,
    output reg              irq_take,
    output reg  [15:0]      vector_addr,
    output reg  [N_IRQ-1:0] irq_flag_clear
);
    localparam ST_RUN  = 2'h0;
    localparam ST_HOLD = 2'h1;
    localparam ST_TIME = 2'h2;
    localparam PIN_CYC = `RVC_PIN_MIN_CYC;

    reg [1:0]  state_reg;
    reg [1:0]  state_next;
    reg [14:0] cnt_reg;
    reg [14:0] limit;
    reg [2:0]  low_cnt_reg;
    reg        pin_rst;
    reg        wdt_pulse_d;
    reg        wdt_expire_d;
    reg        fast_sel;
    reg [4:0]  take_idx_reg;

    wire             enc_any;
    wire [4:0]       enc_idx;
    wire [15:0]      enc_vec;
    wire [N_IRQ-1:0] pending;
    wire             hold_src;
    wire             tick;
    wire             run_next;
    wire             ack_hit;

    // Fuse bits are active-low programmed; code read as printed
    always @* begin
        fast_sel = (startup_time_fuse == `RVC_SUT_FAST);
        case (startup_time_fuse)
            `RVC_SUT_512: begin
                limit = CYC_512[14:0];
            end
            `RVC_SUT_4K: begin
                limit = CYC_4K[14:0];
            end
            `RVC_SUT_16K: begin
                limit = CYC_16K[14:0];
            end
            default: begin
                limit = `RVC_CYC_FAST;
            end
        endcase
    end

    // Pin low filter: two low samples cover the minimum width
    always @(posedge clk) begin
        if (sys_rst) begin
            low_cnt_reg <= 3'h0;
            pin_rst     <= 1'b0;
        end else if (reset_pin_n) begin
            low_cnt_reg <= 3'h0;
            pin_rst     <= 1'b0;
        end else if (low_cnt_reg < PIN_CYC[2:0] - 3'h1) begin
            low_cnt_reg <= low_cnt_reg + 3'h1;
        end else begin
            pin_rst <= 1'b1;
        end
    end

    // Edge of expiry only, so a held level fires once
    always @(posedge clk) begin
        if (sys_rst) begin
            wdt_expire_d  <= 1'b0;
            wdt_rst_pulse <= 1'b0;
            wdt_pulse_d   <= 1'b0;
        end else begin
            wdt_expire_d  <= wdt_expire;
            wdt_rst_pulse <= wdt_enable & wdt_expire & ~wdt_expire_d;
            wdt_pulse_d   <= wdt_rst_pulse;
        end
    end

    // Any hold source keeps the sequencer waiting
    assign hold_src = power_on_det | pin_rst | wdt_rst_pulse;
    assign tick     = fast_sel | wdt_osc_tick;
    assign run_next = (state_next == ST_RUN);

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (hold_src)
                    state_next = ST_HOLD;
            end
            ST_HOLD: begin
                if (!hold_src && !wdt_pulse_d && reset_pin_n)
                    state_next = ST_TIME;
                else if (!hold_src && wdt_pulse_d)
                    state_next = ST_TIME;
            end
            ST_TIME: begin
                if (hold_src)
                    state_next = ST_HOLD;
                else if (tick && cnt_reg >= limit - 15'h0001)
                    state_next = ST_RUN;
            end
            default: begin
                state_next = ST_HOLD;
            end
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_HOLD;
            cnt_reg   <= 15'h0000;
            cpu_rst   <= 1'b1;
            io_rst    <= 1'b1;
        end else begin
            state_reg <= state_next;
            if (state_reg != ST_TIME || state_next != ST_TIME)
                cnt_reg <= 15'h0000;
            else if (tick)
                cnt_reg <= cnt_reg + 15'h0001;
            cpu_rst <= ~run_next;
            io_rst  <= (state_next == ST_HOLD);
        end
    end

    // Reset cause flags survive every reset except sys_rst; power-on leaves the external flag as it was
    always @(posedge clk) begin
        if (power_on_det) begin
            power_on_flag <= 1'b1;
        end else if (sys_rst) begin
            power_on_flag <= 1'b1;
        end else if (flag_clear_power_on) begin
            power_on_flag <= 1'b0;
        end
        if (sys_rst) begin
            external_reset_flag <= 1'b0;
        end else if (pin_rst) begin
            external_reset_flag <= 1'b1;
        end else if (flag_clear_external) begin
            external_reset_flag <= 1'b0;
        end
    end

    assign pending = irq_flag & irq_enable & {N_IRQ{global_ie}};

    rvc_prio_enc #(
        .N   (N_IRQ)
    ) u_enc (
        .req (pending),
        .any (enc_any),
        .idx (enc_idx),
        .vec (enc_vec)
    );

    // Acknowledge of the presented request is the entry point
    assign ack_hit = irq_ack & irq_take;

    // Vector and its index stand while a request is presented
    always @(posedge clk) begin
        if (sys_rst || io_rst) begin
            vector_addr  <= `RVC_VEC_RESET;
            take_idx_reg <= 5'h00;
        end else if (!run_next) begin
            vector_addr  <= `RVC_VEC_RESET;
            take_idx_reg <= 5'h00;
        end else if (!irq_take) begin
            vector_addr  <= enc_vec;
            take_idx_reg <= enc_idx;
        end
    end

    always @(posedge clk) begin
        if (sys_rst || io_rst) begin
            global_ie <= 1'b0;
        end else if (ack_hit) begin
            global_ie <= 1'b0;
        end else if (global_ie_clear) begin
            global_ie <= 1'b0;
        end else if (global_ie_set) begin
            global_ie <= 1'b1;
        end
    end

    // Clear pulse names the source whose vector was taken
    always @(posedge clk) begin
        if (sys_rst || io_rst) begin
            irq_take       <= 1'b0;
            irq_flag_clear <= {N_IRQ{1'b0}};
        end else begin
            irq_take       <= enc_any & run_next & ~ack_hit;
            irq_flag_clear <= {N_IRQ{1'b0}};
            if (ack_hit)
                irq_flag_clear[take_idx_reg] <= 1'b1;
        end
    end
endmodule // rvc_reset_vector
`default_nettype wire

/* pkg/rvc_consts.vh */
// Constants for the reset and vector control block
// Notes on behaviour
// - 23 interrupt sources plus reset, distinct vectors
// - Take source only with own and global enable
// - Reset at 0000, sources two words apart
// - Lowest vector address wins; reset first
// - Reset pin low beyond 50 ns resets
// - Enabled watchdog timeout resets the device
// - Reset restores registers except status, restarts 0000
// - After pin release, hold until timeout elapses
// - Power-on held for selected watchdog-oscillator period
// - Codes 01/10/11 give 512/4K/16K oscillator cycles
// - Code 00 releases after 5 CPU cycles
// - Fuse value zero means programmed
// - Watchdog reset pulse lasts one clock cycle
// - Timeout starts on watchdog pulse falling edge
// - Pin held low extends power-on reset
// - Power-on sets flag; other resets keep it
// - External reset sets flag; watchdog keeps it
// - Interrupt entry clears global enable and flag
`ifndef RVC_CONSTS_VH
`define RVC_CONSTS_VH
`define RVC_NUM_IRQ        23
`define RVC_VEC_RESET      16'h0000
`define RVC_VEC_STEP       16'h0002
`define RVC_SUT_FAST       2'h0
`define RVC_SUT_512        2'h1
`define RVC_SUT_4K         2'h2
`define RVC_SUT_16K        2'h3
`define RVC_CYC_512        15'h0200
`define RVC_CYC_4K         15'h1000
`define RVC_CYC_16K        15'h4000
`define RVC_CYC_FAST       15'h0005
`define RVC_PIN_MIN_NS     50
`define RVC_CLK_PERIOD_NS  25
`define RVC_PIN_MIN_CYC    ((`RVC_PIN_MIN_NS + `RVC_CLK_PERIOD_NS - 1) / `RVC_CLK_PERIOD_NS)
`endif
